// ### rtl/sfrs_pkg.sv
// Types of the fundamental reset sequencer
package sfrs_pkg;
  typedef enum logic [3:0] {
    S_WAIT  = 4'h0,
    S_DFLT  = 4'h1,
    S_UNLK  = 4'h2,
    S_PLL   = 4'h3,
    S_MSMB  = 4'h4,
    S_SSMB  = 4'h5,
    S_HOLD  = 4'h6,
    S_STACK = 4'h7,
    S_RUN   = 4'h8,
    S_DONE  = 4'h9
  } sfrs_state_t;
  typedef struct packed {
    logic [3:0] switch_mode_strap;
    logic       reset_hold_strap;
    logic [3:0] slave_smbus_addr_strap;
    logic [3:0] master_smbus_addr_strap;
    logic       master_smbus_slow_strap;
  } sfrs_boot_t;
endpackage

// ### rtl/sfrs_regs.svh
// Offsets, field positions, response codes and timing for the reset sequencer
`ifndef SFRS_REGS_SVH
`define SFRS_REGS_SVH
`define SFRS_CTRL_OFS   8'h00
`define SFRS_BOOT_OFS   8'h04
`define SFRS_STAT_OFS   8'h08
`define SFRS_CTRL_UNLK  0
`define SFRS_CTRL_HOLD  1
`define SFRS_STAT_L20   8
`define SFRS_STAT_L100  9
`define SFRS_STAT_DONE  10
`define SFRS_RESP_OK    2'h0
`define SFRS_RESP_ERR   2'h2
`define SFRS_CLK_KHZ    100000
`define SFRS_STACK_MS   20
`define SFRS_DONE_MS    100
`endif

// ### rtl/sfrs_seq.sv
// Fundamental reset sequencer with AXI4-Lite control and status registers
`timescale 1ns/1ps
`include "sfrs_regs.svh"
module sfrs_seq import sfrs_pkg::*; #(
  parameter int          T20_CYC  = `SFRS_STACK_MS * `SFRS_CLK_KHZ,
  parameter int          T100_CYC = `SFRS_DONE_MS * `SFRS_CLK_KHZ,
  parameter logic [15:0] EE_MODES = 16'h00FF,
  parameter logic [6:0]  MSMB_BASE = 7'h50,
  parameter logic [6:0]  SSMB_BASE = 7'h40
) (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       global_reset_in_n_i,
  input  wire sfrs_boot_t straps_i,
  input  wire logic       pll_lock_i,
  input  wire logic       ports_trained_i,
  input  wire logic       eeprom_done_i,
  output logic            pll_init_o,
  output logic            msmb_en_o,
  output logic            msmb_slow_o,
  output logic [6:0]      msmb_addr_o,
  output logic            ssmb_en_o,
  output logic [6:0]      ssmb_addr_o,
  output logic            stack_rst_n_o,
  output logic            link_train_o,
  output logic            eeprom_rd_o,
  output logic            seq_done_o,
  input  wire logic [7:0] s_axi_awaddr,
  input  wire logic       s_axi_awvalid,
  output logic            s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0] s_axi_wstrb,
  input  wire logic       s_axi_wvalid,
  output logic            s_axi_wready,
  output logic [1:0]      s_axi_bresp,
  output logic            s_axi_bvalid,
  input  wire logic       s_axi_bready,
  input  wire logic [7:0] s_axi_araddr,
  input  wire logic       s_axi_arvalid,
  output logic            s_axi_arready,
  output logic [31:0]     s_axi_rdata,
  output logic [1:0]      s_axi_rresp,
  output logic            s_axi_rvalid,
  input  wire logic       s_axi_rready
);
  // -----------------------------------------------------------------
  // Pin synchronisers
  // -----------------------------------------------------------------
  // Straps, reset pin and PLL lock come from outside the clock domain
  logic [15:0] sy1_q, sy2_q;
  logic        rst_n_s, pll_lock_s;
  sfrs_boot_t  strap_s;
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      sy1_q <= 16'h0;
      sy2_q <= 16'h0;
    end else begin
      sy1_q <= {pll_lock_i, global_reset_in_n_i, straps_i};
      sy2_q <= sy1_q;
    end
  end
  assign strap_s    = sy2_q[13:0];
  assign rst_n_s    = sy2_q[14];
  assign pll_lock_s = sy2_q[15];

  // -----------------------------------------------------------------
  // Sequencer
  // -----------------------------------------------------------------
  sfrs_state_t state_q;
  sfrs_boot_t  boot_q;
  logic        unlk_q, hold_q, wr_en;
  logic [1:0]  wsel;
  logic [31:0] wdat_q;
  logic        ee_need;
  assign ee_need = EE_MODES[boot_q.switch_mode_strap];

  // Power-on and a later pin reset both land in S_WAIT: no cold/warm split
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i || !rst_n_s) begin
      state_q <= S_WAIT;
    end else begin
      unique case (state_q)
        S_WAIT:  state_q <= S_DFLT;
        S_DFLT:  state_q <= S_UNLK;
        S_UNLK:  state_q <= S_PLL;
        S_PLL:   if (pll_lock_s) state_q <= S_MSMB;
        S_MSMB:  state_q <= S_SSMB;
        S_SSMB:  state_q <= S_HOLD;
        S_HOLD:  if (!hold_q) state_q <= S_STACK;
        S_STACK: state_q <= S_RUN;
        S_RUN:   if (ports_trained_i && (!ee_need || eeprom_done_i)) begin
          state_q <= S_DONE;
        end
        S_DONE:  state_q <= S_DONE;
      endcase
    end
  end

  // Captured only on leaving S_WAIT, so it holds until the next reset
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      boot_q <= '0;
    end else if (state_q == S_WAIT && rst_n_s) begin
      boot_q <= strap_s;
    end
  end

  // Control register; hardware set of unlock wins over a write
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i || state_q == S_DFLT) begin
      unlk_q <= 1'b0;
      hold_q <= (state_q == S_DFLT) ? boot_q.reset_hold_strap : 1'b0;
    end else if (state_q == S_UNLK) begin
      unlk_q <= 1'b1;
    end else if (wr_en && wsel == 2'h0 && s_axi_wstrb[0]) begin
      unlk_q <= wdat_q[`SFRS_CTRL_UNLK];
      hold_q <= hold_q & wdat_q[`SFRS_CTRL_HOLD];
    end
  end

  // Outputs; everything past S_WAIT is dropped again by a new reset
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i || state_q == S_WAIT) begin
      pll_init_o    <= 1'b0;
      msmb_en_o     <= 1'b0;
      msmb_slow_o   <= 1'b0;
      msmb_addr_o   <= MSMB_BASE;
      ssmb_en_o     <= 1'b0;
      ssmb_addr_o   <= SSMB_BASE;
      stack_rst_n_o <= 1'b0;
      link_train_o  <= 1'b0;
      eeprom_rd_o   <= 1'b0;
      seq_done_o    <= 1'b0;
    end else begin
      if (state_q == S_UNLK) pll_init_o <= 1'b1;
      if (state_q == S_MSMB) begin
        msmb_en_o        <= 1'b1;
        msmb_slow_o      <= boot_q.master_smbus_slow_strap;
        msmb_addr_o[4:1] <= boot_q.master_smbus_addr_strap;
      end
      if (state_q == S_SSMB) begin
        ssmb_en_o <= 1'b1;
        {ssmb_addr_o[5], ssmb_addr_o[3:1]} <= boot_q.slave_smbus_addr_strap;
      end
      if (state_q == S_STACK) begin
        stack_rst_n_o <= 1'b1;
        link_train_o  <= 1'b1;
      end
      // Loader runs while ports train, not after
      eeprom_rd_o <= state_q == S_RUN && ee_need && !eeprom_done_i;
      if (state_q == S_DONE) seq_done_o <= 1'b1;
    end
  end

  // -----------------------------------------------------------------
  // Deadline timer
  // -----------------------------------------------------------------
  // Only reports misses: lock and hold are external, so cannot be forced
  logic [31:0] tmr_q;
  logic        late20_q, late100_q;
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i || state_q == S_WAIT) begin
      tmr_q     <= 32'h0;
      late20_q  <= 1'b0;
      late100_q <= 1'b0;
    end else begin
      if (tmr_q < 32'(T100_CYC)) tmr_q <= tmr_q + 32'h1;
      if (tmr_q == 32'(T20_CYC) && !stack_rst_n_o) late20_q <= 1'b1;
      if (tmr_q == 32'(T100_CYC) && !seq_done_o) late100_q <= 1'b1;
    end
  end

  // -----------------------------------------------------------------
  // AXI4-Lite slave
  // -----------------------------------------------------------------
  function automatic logic [1:0] reg_sel(input logic [7:0] a);
    if (a == `SFRS_CTRL_OFS) return 2'h0;
    if (a == `SFRS_BOOT_OFS) return 2'h1;
    if (a == `SFRS_STAT_OFS) return 2'h2;
    return 2'h3;
  endfunction

  logic       aw_got_q, w_got_q;
  logic [7:0] awa_q;
  assign wsel  = reg_sel(awa_q);
  assign wr_en = aw_got_q && w_got_q && !s_axi_bvalid;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SFRS_RESP_OK;
      aw_got_q      <= 1'b0;
      w_got_q       <= 1'b0;
      awa_q         <= 8'h0;
      wdat_q        <= 32'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q      <= 1'b1;
        awa_q         <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else begin
        s_axi_awready <= !aw_got_q && !s_axi_bvalid;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q      <= 1'b1;
        wdat_q       <= s_axi_wdata;
        s_axi_wready <= 1'b0;
      end else begin
        s_axi_wready <= !w_got_q && !s_axi_bvalid;
      end
      if (wr_en) begin
        aw_got_q     <= 1'b0;
        w_got_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wsel == 2'h3) ? `SFRS_RESP_ERR : `SFRS_RESP_OK;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  logic [1:0] rsel;
  assign rsel = reg_sel(s_axi_araddr);
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `SFRS_RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= (rsel == 2'h3) ? `SFRS_RESP_ERR : `SFRS_RESP_OK;
      unique case (rsel)
        2'h0:    s_axi_rdata <= {30'h0, hold_q, unlk_q};
        2'h1:    s_axi_rdata <= {18'h0, boot_q};
        2'h2:    s_axi_rdata <= {21'h0, seq_done_o, late100_q, late20_q, 4'h0, state_q};
        default: s_axi_rdata <= 32'h0;
      endcase
    end else begin
      if (s_axi_rvalid && s_axi_rready) s_axi_rvalid <= 1'b0;
      s_axi_arready <= !s_axi_rvalid;
    end
  end

  // -----------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);

  a_wait_in_reset: assert property (!rst_n_s |=> state_q == S_WAIT)
    else $error("left wait state during reset");
  a_boot_capture: assert property (state_q == S_WAIT && rst_n_s |=> boot_q == $past(strap_s))
    else $error("boot vector not captured");
  a_boot_stable: assert property ($past(state_q) != S_WAIT |-> $stable(boot_q))
    else $error("boot vector changed");
  a_dflt_unlock: assert property (state_q == S_DFLT && rst_n_s |=> !unlk_q ##1 unlk_q)
    else $error("unlock not set after defaulting");
  a_pll_wait: assert property (state_q == S_PLL && !pll_lock_s && rst_n_s |=> state_q == S_PLL)
    else $error("left pll wait without lock");
  a_msmb_cfg: assert property (msmb_en_o |-> msmb_addr_o[4:1] == boot_q.master_smbus_addr_strap
    && msmb_slow_o == boot_q.master_smbus_slow_strap)
    else $error("master smbus config mismatch");
  a_ssmb_cfg: assert property (ssmb_en_o |-> {ssmb_addr_o[5], ssmb_addr_o[3:1]}
    == boot_q.slave_smbus_addr_strap)
    else $error("slave smbus address mismatch");
  a_stack_order: assert property ($rose(stack_rst_n_o) |-> ssmb_en_o && msmb_en_o
    && pll_init_o && !hold_q && link_train_o)
    else $error("stacks released out of order");
  a_hold_stack: assert property (hold_q && state_q == S_HOLD |=> !stack_rst_n_o)
    else $error("stacks released under hold");
  a_ee_parallel: assert property (state_q == S_RUN && ee_need && !eeprom_done_i && rst_n_s
    |=> eeprom_rd_o && stack_rst_n_o && !seq_done_o)
    else $error("eeprom load not parallel");
  a_done_trained: assert property ($rose(seq_done_o) |-> $past(ports_trained_i, 2))
    else $error("done before ports trained");
  a_late100: assert property ($rose(late100_q) |-> !seq_done_o)
    else $error("late flag with done");

  c_done: cover property ($rose(seq_done_o));
  c_hold: cover property (state_q == S_HOLD ##1 state_q == S_HOLD ##1 state_q == S_STACK);
  c_warm: cover property (seq_done_o ##1 !rst_n_s);
  c_bad_rd: cover property (s_axi_rvalid && s_axi_rresp == `SFRS_RESP_ERR);
endmodule // sfrs_seq

// ### test/sfrs_rst_src.sv
// Reset source with lock, training and EEPROM responders for the sequencer
`timescale 1ns/1ps
module sfrs_rst_src (
  input  wire logic       ref_clk_i,
  input  wire logic       pin_low_i,
  input  wire logic [7:0] lag_i,
  input  wire logic       pll_init_i,
  input  wire logic       link_train_i,
  input  wire logic       eeprom_rd_i,
  output logic            global_reset_in_n_o,
  output logic            pll_lock_o,
  output logic            ports_trained_o,
  output logic            eeprom_done_o
);
  // ----------------------------------------
  // Far-side behaviour
  // ----------------------------------------
  // Counters settle once the sequencer's reset clears init and training
  logic [7:0] pll_q;
  logic [7:0] trn_q;
  always_ff @(posedge ref_clk_i) begin
    global_reset_in_n_o <= !pin_low_i;
  end
  // Lock comes lag cycles after init and is lost with it
  always_ff @(posedge ref_clk_i) begin
    if (!pll_init_i) pll_q <= 8'h00;
    else if (pll_q != 8'hFF) pll_q <= pll_q + 8'h01;
    pll_lock_o <= pll_init_i && (pll_q >= lag_i);
  end
  // Training and EEPROM load finish lag cycles after training starts
  always_ff @(posedge ref_clk_i) begin
    if (!link_train_i) trn_q <= 8'h00;
    else if (trn_q != 8'hFF) trn_q <= trn_q + 8'h01;
    ports_trained_o <= link_train_i && (trn_q >= lag_i);
    eeprom_done_o   <= link_train_i && (eeprom_done_o || (eeprom_rd_i && trn_q >= lag_i));
  end
endmodule // sfrs_rst_src

// ### test/test_sfrs_seq.sv
// Self-checking bench for the fundamental reset sequencer
`timescale 1ns/1ps
`include "sfrs_regs.svh"
module test_sfrs_seq import sfrs_pkg::*; ;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  localparam logic [6:0] MB = 7'h50;
  localparam logic [6:0] SB = 7'h40;
  logic        ref_clk_i = 1'b0;
  logic        rst_b_i   = 1'b0;
  logic        pin_low   = 1'b1;
  logic [7:0]  lag       = 8'h02;
  sfrs_boot_t  straps    = '0;
  logic        glb_rst_n, lock, trained, ee_done, pll_init, msmb_en, msmb_slow;
  logic        ssmb_en, stack_rst_n, link_train, ee_rd, done;
  logic [6:0]  msmb_addr, ssmb_addr;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata  = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic [31:0] rdata;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [33:0] exp_q[$];
  int          num_errors = 0;
  int          cmp_count  = 0;
  always #5 ref_clk_i = ~ref_clk_i;
  sfrs_seq #(.T20_CYC(200), .T100_CYC(1000), .EE_MODES(16'h00FF), .MSMB_BASE(MB),
    .SSMB_BASE(SB)) dut_u (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .global_reset_in_n_i(glb_rst_n),
    .straps_i(straps), .pll_lock_i(lock), .ports_trained_i(trained), .eeprom_done_i(ee_done),
    .pll_init_o(pll_init), .msmb_en_o(msmb_en), .msmb_slow_o(msmb_slow),
    .msmb_addr_o(msmb_addr), .ssmb_en_o(ssmb_en), .ssmb_addr_o(ssmb_addr),
    .stack_rst_n_o(stack_rst_n), .link_train_o(link_train), .eeprom_rd_o(ee_rd),
    .seq_done_o(done), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  sfrs_rst_src src_u (.ref_clk_i(ref_clk_i), .pin_low_i(pin_low), .lag_i(lag),
    .pll_init_i(pll_init), .link_train_i(link_train), .eeprom_rd_i(ee_rd),
    .global_reset_in_n_o(glb_rst_n), .pll_lock_o(lock), .ports_trained_o(trained),
    .eeprom_done_o(ee_done));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic time_out();
    num_errors++;
    report_and_stop();
  endtask
  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int k;
    exp_q.push_back({r, 32'h0});
    @(posedge ref_clk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 200; k++) begin
      @(posedge ref_clk_i);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (k == 200) time_out();
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [33:0] e);
    int k;
    exp_q.push_back(e);
    @(posedge ref_clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 200; k++) begin
      @(posedge ref_clk_i);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    if (k == 200) time_out();
  endtask
  task automatic wait_hi(input logic which, output int n);
    for (n = 0; n < 2000; n++) begin
      @(posedge ref_clk_i);
      if ((which ? done : stack_rst_n) === 1'b1) break;
    end
    if (n == 2000) time_out();
  endtask
  // Bus answers are matched against the oldest note
  always @(posedge ref_clk_i) begin
    if (rvalid && rready) chk("read", exp_q.pop_front(), {rresp, rdata});
    if (bvalid && bready) chk("write resp", exp_q.pop_front(), {bresp, 32'h0});
  end
  // ----------------------------------------
  // Sequence: cold, warm, warm with hold
  // ----------------------------------------
  initial begin
    sfrs_boot_t st;
    int p;
    int n;
    void'($urandom(32'h1C32));
    repeat (6) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    for (p = 0; p < 3; p++) begin
      st = sfrs_boot_t'(14'($urandom));
      st.reset_hold_strap = (p == 2);
      // One pass without and two with a loader-backed switch mode
      st.switch_mode_strap[3] = (p == 1);
      lag <= (p == 1) ? 8'h20 : 8'h02;
      straps <= st;
      pin_low <= 1'b1;
      repeat (40) @(posedge ref_clk_i);
      chk("stack_rst_n low", 34'h0, {33'h0, stack_rst_n});
      chk("seq_done low", 34'h0, {33'h0, done});
      pin_low <= 1'b0;
      repeat (10) @(posedge ref_clk_i);
      // Strap changes after capture must not reach the vector
      straps <= ~st;
      if (p == 2) begin
        repeat (60) @(posedge ref_clk_i);
        chk("held stack_rst_n", 34'h0, {33'h0, stack_rst_n});
        axi_rd(`SFRS_CTRL_OFS, 34'h3);
        axi_wr(`SFRS_CTRL_OFS, 32'h1, `SFRS_RESP_OK);
      end
      wait_hi(1'b0, n);
      chk("release time", 34'h1, {33'h0, (n + 11 <= 200)});
      chk("msmb_slow", {33'h0, st.master_smbus_slow_strap}, {33'h0, msmb_slow});
      chk("msmb_addr", {27'h0, MB[6:5], st.master_smbus_addr_strap, MB[0]},
        {27'h0, msmb_addr});
      chk("ssmb_addr", {27'h0, SB[6], st.slave_smbus_addr_strap[3], SB[4],
        st.slave_smbus_addr_strap[2:0], SB[0]}, {27'h0, ssmb_addr});
      chk("enables", 34'hF, {30'h0, pll_init, msmb_en, ssmb_en, link_train});
      wait_hi(1'b1, n);
      chk("done time", 34'h1, {33'h0, (n <= 1000)});
      axi_rd(`SFRS_BOOT_OFS, {20'h0, st});
      axi_rd(`SFRS_CTRL_OFS, 34'h1);
      axi_rd(`SFRS_STAT_OFS, 34'h409);
      $display("test %0d finished", p);
    end
    axi_wr(`SFRS_BOOT_OFS, 32'hFFFF, `SFRS_RESP_OK);
    axi_rd(`SFRS_BOOT_OFS, {20'h0, st});
    axi_rd(8'h0C, {`SFRS_RESP_ERR, 32'h0});
    $display("test 3 finished");
    report_and_stop();
  end
endmodule // test_sfrs_seq
